// >>> core/cwm_divider.v
// Iterative unsigned divider, two quotient bits per clock.
// Assumes load_i is a one-cycle pulse and operands are stable at it.
`timescale 1ns/100ps
`default_nettype none
`include "cwm_map.vh"

module cwm_divider (
    // Clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // Control
    input wire load_i,
    input wire wide_i,
    // Operands
    input wire [31:0] dividend_i,
    input wire [31:0] divisor_i,
    // Results
    output wire [31:0] quot_o,
    output wire [31:0] rem_o
);

    reg [31:0] rem_q;
    reg [31:0] quo_q;
    reg [31:0] dsr_q;
    reg [4:0] steps_q;
    reg [63:0] s1;
    reg [63:0] s2;

    // One restoring step: shift in next dividend bit, subtract if it fits
    function [63:0] div_step;
        input [31:0] r;
        input [31:0] q;
        input [31:0] d;
        reg [32:0] t;
        begin
            t = {r, q[31]};
            if (t >= {1'b0, d}) begin
                t = t - {1'b0, d};
                div_step = {t[31:0], q[30:0], 1'b1};
            end else begin
                div_step = {t[31:0], q[30:0], 1'b0};
            end
        end
    endfunction

    // Two chained steps per clock
    always @* begin
        s1 = div_step(rem_q, quo_q, dsr_q);
        s2 = div_step(s1[63:32], s1[31:0], dsr_q);
    end

    // Load aligns a 16-bit dividend to the top so both widths share one path
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rem_q <= `CWM_RST_DWORD;
            quo_q <= `CWM_RST_DWORD;
            dsr_q <= `CWM_RST_DWORD;
            steps_q <= 5'h00;
        end else if (load_i) begin
            rem_q <= `CWM_RST_DWORD;
            quo_q <= wide_i ? dividend_i : {dividend_i[15:0], 16'h0000};
            dsr_q <= divisor_i;
            steps_q <= wide_i ? `CWM_DIV_STEPS_DWORD : `CWM_DIV_STEPS_WORD;
        end else if (steps_q != 5'h00) begin
            rem_q <= s2[63:32];
            quo_q <= s2[31:0];
            steps_q <= steps_q - 5'h01;
        end
    end

    assign quot_o = quo_q;
    assign rem_o = rem_q;

endmodule // cwm_divider
`default_nettype wire

// >>> core/cwm_map.vh
// Constants for the compare, word arithmetic and multiply/divide unit.
// Assumes a CPU-side sequencer that issues one operation at a time.
`ifndef CWM_MAP_VH
`define CWM_MAP_VH

// ****************************************************************
// Operation codes
// ****************************************************************
`define CWM_OP_W 4
`define CWM_OP_BYTE_CMP 4'h0
`define CWM_OP_CMP_ZERO 4'h1
`define CWM_OP_IDX_CMP 4'h2
`define CWM_OP_WORD_CMP 4'h3
`define CWM_OP_WORD_ADD 4'h4
`define CWM_OP_WORD_SUB 4'h5
`define CWM_OP_BYTE_MUL 4'h6
`define CWM_OP_UWORD_MUL 4'h7
`define CWM_OP_SWORD_MUL 4'h8
`define CWM_OP_WORD_DIV 4'h9
`define CWM_OP_DWORD_DIV 4'hA
`define CWM_OP_UMAC 4'hB
`define CWM_OP_SMAC 4'hC

// ****************************************************************
// Clock counts
// ****************************************************************
`define CWM_CNT_W 6
`define CWM_CLK_PLAIN 6'h01
`define CWM_CLK_SEG 6'h02
`define CWM_CLK_FLASH 6'h04
`define CWM_CLK_FLASH_SEG 6'h05
`define CWM_CLK_BYTE_MUL 6'h01
`define CWM_CLK_WORD_MUL 6'h02
`define CWM_CLK_WORD_DIV 6'h09
`define CWM_CLK_DWORD_DIV 6'h11
`define CWM_CLK_MAC 6'h03
`define CWM_CLK_RAM_EXTRA 6'h03

// ****************************************************************
// Flag write mask bits, divider step counts and reset values
// ****************************************************************
`define CWM_FLAG_Z 2
`define CWM_FLAG_AC 1
`define CWM_FLAG_CY 0
`define CWM_DIV_STEPS_WORD 5'h08
`define CWM_DIV_STEPS_DWORD 5'h10
`define CWM_RST_WORD 16'h0000
`define CWM_RST_DWORD 32'h0000_0000

`endif

// >>> core/cwm_unit.v
// Compare, word add/subtract, multiply, divide and product-sum datapath.
// Assumes the sequencer holds operands stable on the start pulse and
// writes committed results back when done_o pulses.
`timescale 1ns/100ps
`default_nettype none
`include "cwm_map.vh"

module cwm_unit (
    // Clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // Operation request
    input wire start_i,
    input wire [3:0] op_i,
    input wire flash_src_i,
    input wire seg_prefix_i,
    input wire ram_fetch_i,
    // Operands
    input wire [15:0] accumulator_pair_i,
    input wire [15:0] multiplier_pair_i,
    input wire [15:0] divisor_pair_i,
    input wire [15:0] index_pair_i,
    input wire [15:0] opnd_a_i,
    input wire [15:0] opnd_b_i,
    // Product-sum register software access
    input wire psum_wr_hi_i,
    input wire psum_wr_lo_i,
    input wire [15:0] psum_wdata_i,
    // Status
    output wire busy_o,
    output reg done_o,
    // Results
    output reg [15:0] accumulator_pair_o,
    output reg [15:0] multiplier_pair_o,
    output reg [15:0] divisor_pair_o,
    output reg [15:0] index_pair_o,
    output reg [3:0] pair_wr_o,
    output reg zero_flag_o,
    output reg half_carry_flag_o,
    output reg carry_out_flag_o,
    output reg [2:0] flag_wr_o,
    output wire [15:0] psum_hi_o,
    output wire [15:0] psum_lo_o
);

    // ************************************************************
    // Declarations
    // ************************************************************
    reg [5:0] cnt_q;
    reg [3:0] op_q;
    reg [15:0] ax_p_q;
    reg [15:0] bc_p_q;
    reg [3:0] wr_p_q;
    reg [2:0] flag_p_q;
    reg [2:0] fwr_p_q;
    reg [31:0] product_sum_register_q;
    reg [31:0] psum_p_q;
    reg [5:0] base_d;
    reg [5:0] cnt_d;
    reg [15:0] ax_d;
    reg [15:0] bc_d;
    reg [3:0] wr_d;
    reg [2:0] flag_d;
    reg [2:0] fwr_d;
    reg [31:0] psum_d;
    reg [17:0] diff_d;
    reg [31:0] prod_d;
    reg [32:0] mac_d;
    wire take_w;
    wire [31:0] quot_w;
    wire [31:0] rem_w;

    assign take_w = start_i && (cnt_q == 6'h00);
    assign busy_o = (cnt_q != 6'h00);

    // ************************************************************
    // Arithmetic helpers
    // ************************************************************

    // Returns {Z, AC, CY} for a - b (or a + b) over a byte or a word
    function [2:0] arith_flags;
        input [15:0] a;
        input [15:0] b;
        input sub;
        input wide;
        reg [16:0] r;
        reg [4:0] n;
        begin
            r = sub ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + {1'b0, b});
            n = sub ? ({1'b0, a[3:0]} - {1'b0, b[3:0]}) : ({1'b0, a[3:0]} + {1'b0, b[3:0]});
            if (wide) begin
                arith_flags = {(r[15:0] == 16'h0000), n[4], r[16]};
            end else begin
                r = sub ? ({9'h000, a[7:0]} - {9'h000, b[7:0]})
                        : ({9'h000, a[7:0]} + {9'h000, b[7:0]});
                arith_flags = {(r[7:0] == 8'h00), n[4], r[8]};
            end
        end
    endfunction

    // Clock count for compare and add/subtract memory forms
    function [5:0] mem_clocks;
        input flash;
        input seg;
        begin
            if (flash) begin
                mem_clocks = seg ? `CWM_CLK_FLASH_SEG : `CWM_CLK_FLASH;
            end else begin
                mem_clocks = seg ? `CWM_CLK_SEG : `CWM_CLK_PLAIN;
            end
        end
    endfunction

    // 16 x 16 product, operands widened on purpose; low 32 bits hold
    // the signed product too when both are sign-extended
    function [31:0] mul16;
        input [15:0] a;
        input [15:0] b;
        input sgn;
        reg [31:0] ae;
        reg [31:0] be;
        begin
            ae = {{16{sgn & a[15]}}, a};
            be = {{16{sgn & b[15]}}, b};
            mul16 = ae * be;
        end
    endfunction

    // ************************************************************
    // Result and timing decode
    // ************************************************************

    // Computes pending results at the take edge; commit happens later
    always @* begin
        base_d = mem_clocks(flash_src_i, seg_prefix_i);
        ax_d = accumulator_pair_i;
        bc_d = multiplier_pair_i;
        wr_d = 4'h0;
        flag_d = 3'h0;
        fwr_d = 3'h0;
        psum_d = product_sum_register_q;
        diff_d = 18'h00000;
        prod_d = 32'h0000_0000;
        mac_d = 33'h0_0000_0000;
        case (op_i)
            `CWM_OP_BYTE_CMP: begin
                flag_d = arith_flags(opnd_a_i, opnd_b_i, 1'b1, 1'b0);
                fwr_d = 3'h7;
            end
            `CWM_OP_CMP_ZERO: begin
                flag_d = {(opnd_a_i[7:0] == 8'h00), 2'b00};
                fwr_d = 3'h7;
            end
            `CWM_OP_IDX_CMP: begin
                flag_d = arith_flags({8'h00, accumulator_pair_i[7:0]}, opnd_b_i,
                                     1'b1, 1'b0);
                fwr_d = 3'h7;
            end
            `CWM_OP_WORD_CMP: begin
                flag_d = arith_flags(accumulator_pair_i, opnd_b_i, 1'b1, 1'b1);
                fwr_d = 3'h7;
            end
            `CWM_OP_WORD_ADD: begin
                ax_d = accumulator_pair_i + opnd_b_i;
                flag_d = arith_flags(accumulator_pair_i, opnd_b_i, 1'b0, 1'b1);
                wr_d = 4'h1;
                fwr_d = 3'h7;
            end
            `CWM_OP_WORD_SUB: begin
                ax_d = accumulator_pair_i - opnd_b_i;
                flag_d = arith_flags(accumulator_pair_i, opnd_b_i, 1'b1, 1'b1);
                wr_d = 4'h1;
                fwr_d = 3'h7;
            end
            `CWM_OP_BYTE_MUL: begin
                base_d = `CWM_CLK_BYTE_MUL;
                ax_d = {8'h00, accumulator_pair_i[15:8]} * {8'h00, accumulator_pair_i[7:0]};
                wr_d = 4'h1;
            end
            `CWM_OP_UWORD_MUL: begin
                base_d = `CWM_CLK_WORD_MUL;
                prod_d = mul16(accumulator_pair_i, multiplier_pair_i, 1'b0);
                {bc_d, ax_d} = prod_d;
                wr_d = 4'h3;
            end
            `CWM_OP_SWORD_MUL: begin
                base_d = `CWM_CLK_WORD_MUL;
                prod_d = mul16(accumulator_pair_i, multiplier_pair_i, 1'b1);
                {bc_d, ax_d} = prod_d;
                wr_d = 4'h3;
            end
            `CWM_OP_WORD_DIV: begin
                base_d = `CWM_CLK_WORD_DIV;
                wr_d = 4'h5;
            end
            `CWM_OP_DWORD_DIV: begin
                base_d = `CWM_CLK_DWORD_DIV;
                wr_d = 4'hF;
            end
            `CWM_OP_UMAC, `CWM_OP_SMAC: begin
                base_d = `CWM_CLK_MAC;
                if (op_i == `CWM_OP_SMAC) begin
                    prod_d = mul16(accumulator_pair_i, multiplier_pair_i, 1'b1);
                end else begin
                    prod_d = mul16(accumulator_pair_i, multiplier_pair_i, 1'b0);
                end
                mac_d = {1'b0, product_sum_register_q} + {1'b0, prod_d};
                diff_d = {2'b00, product_sum_register_q[15:0]} + {2'b00, prod_d[15:0]};
                psum_d = mac_d[31:0];
                if (op_i == `CWM_OP_SMAC) begin
                    // Signed overflow on the accumulation
                    flag_d = {1'b0, diff_d[16], (product_sum_register_q[31] == prod_d[31])
                              && (mac_d[31] != prod_d[31])};
                end else begin
                    flag_d = {1'b0, diff_d[16], mac_d[32]};
                end
                fwr_d = 3'h3;
            end
            default: begin
                base_d = `CWM_CLK_PLAIN;
            end
        endcase
        // Fetching from RAM stretches the operation to twice plus three
        cnt_d = ram_fetch_i ? ((base_d << 1) + `CWM_CLK_RAM_EXTRA) : base_d;
    end

    // ************************************************************
    // Sequencer and commit
    // ************************************************************

    // Counts the operation's clocks and commits results on the last one
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 6'h00;
            op_q <= `CWM_OP_BYTE_CMP;
            ax_p_q <= `CWM_RST_WORD;
            bc_p_q <= `CWM_RST_WORD;
            wr_p_q <= 4'h0;
            flag_p_q <= 3'h0;
            fwr_p_q <= 3'h0;
            psum_p_q <= `CWM_RST_DWORD;
            done_o <= 1'b0;
            accumulator_pair_o <= `CWM_RST_WORD;
            multiplier_pair_o <= `CWM_RST_WORD;
            divisor_pair_o <= `CWM_RST_WORD;
            index_pair_o <= `CWM_RST_WORD;
            pair_wr_o <= 4'h0;
            zero_flag_o <= 1'b0;
            half_carry_flag_o <= 1'b0;
            carry_out_flag_o <= 1'b0;
            flag_wr_o <= 3'h0;
        end else begin
            done_o <= 1'b0;
            pair_wr_o <= 4'h0;
            flag_wr_o <= 3'h0;
            if (take_w) begin
                cnt_q <= cnt_d;
                op_q <= op_i;
                ax_p_q <= ax_d;
                bc_p_q <= bc_d;
                wr_p_q <= wr_d;
                flag_p_q <= flag_d;
                fwr_p_q <= fwr_d;
                psum_p_q <= psum_d;
            end else if (cnt_q != 6'h00) begin
                cnt_q <= cnt_q - 6'h01;
                if (cnt_q == 6'h01) begin
                    done_o <= 1'b1;
                    pair_wr_o <= wr_p_q;
                    flag_wr_o <= fwr_p_q;
                    {zero_flag_o, half_carry_flag_o, carry_out_flag_o} <= flag_p_q;
                    if (op_q == `CWM_OP_WORD_DIV) begin
                        accumulator_pair_o <= quot_w[15:0];
                        divisor_pair_o <= rem_w[15:0];
                    end else if (op_q == `CWM_OP_DWORD_DIV) begin
                        {multiplier_pair_o, accumulator_pair_o} <= quot_w;
                        {index_pair_o, divisor_pair_o} <= rem_w;
                    end else begin
                        accumulator_pair_o <= ax_p_q;
                        multiplier_pair_o <= bc_p_q;
                    end
                end
            end
        end
    end

    // Product-sum register: software halves, accumulate at commit
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            product_sum_register_q <= `CWM_RST_DWORD;
        end else if ((cnt_q == 6'h01) && !take_w &&
                     ((op_q == `CWM_OP_UMAC) || (op_q == `CWM_OP_SMAC))) begin
            product_sum_register_q <= psum_p_q;
        end else begin
            if (psum_wr_hi_i) begin
                product_sum_register_q[31:16] <= psum_wdata_i;
            end
            if (psum_wr_lo_i) begin
                product_sum_register_q[15:0] <= psum_wdata_i;
            end
        end
    end

    assign psum_hi_o = product_sum_register_q[31:16];
    assign psum_lo_o = product_sum_register_q[15:0];

    // Divider is loaded on the take edge; results are read at commit
    cwm_divider u_div (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .load_i(take_w && ((op_i == `CWM_OP_WORD_DIV) || (op_i == `CWM_OP_DWORD_DIV))),
        .wide_i(op_i == `CWM_OP_DWORD_DIV),
        .dividend_i({multiplier_pair_i, accumulator_pair_i} &
                    {{16{op_i == `CWM_OP_DWORD_DIV}}, 16'hFFFF}),
        .divisor_i({index_pair_i, divisor_pair_i} &
                   {{16{op_i == `CWM_OP_DWORD_DIV}}, 16'hFFFF}),
        .quot_o(quot_w),
        .rem_o(rem_w)
    );

endmodule // cwm_unit
`default_nettype wire

// >>> core/none.v
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// >>> verification/cwm_unit_asserts.sv
// Port-level checker for the compare, arithmetic and multiply/divide unit.
// Assumes it is bound to cwm_unit and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
`include "cwm_map.vh"

module cwm_unit_asserts (
    // Clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // Request and operands
    input wire start_i,
    input wire [3:0] op_i,
    input wire flash_src_i,
    input wire seg_prefix_i,
    input wire ram_fetch_i,
    input wire [15:0] accumulator_pair_i,
    input wire [15:0] opnd_b_i,
    input wire psum_wr_lo_i,
    input wire [15:0] psum_wdata_i,
    // Results
    input wire busy_o,
    input wire done_o,
    input wire [15:0] accumulator_pair_o,
    input wire [3:0] pair_wr_o,
    input wire half_carry_flag_o,
    input wire carry_out_flag_o,
    input wire [2:0] flag_wr_o,
    input wire [15:0] psum_lo_o
);
    // ****
    // Request qualifiers
    // ****
    wire take = start_i && !busy_o;
    wire plain = !flash_src_i && !seg_prefix_i && !ram_fetch_i;
    wire flash_op = flash_src_i && !ram_fetch_i && op_i <= `CWM_OP_WORD_SUB;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    cmp_no_write_a:
        assert property (take && plain && (op_i == `CWM_OP_BYTE_CMP ||
            op_i == `CWM_OP_IDX_CMP || op_i == `CWM_OP_WORD_CMP) |->
            ##2 (done_o && pair_wr_o == 4'h0 && flag_wr_o == 3'h7))
        else $error("compare wrote a pair or missed a flag");
    cmp_zero_flags_a:
        assert property (take && plain && op_i == `CWM_OP_CMP_ZERO |-> ##2 (done_o &&
            !half_carry_flag_o && !carry_out_flag_o && pair_wr_o == 4'h0))
        else $error("compare with zero left a carry flag set");
    add_sum_a:
        assert property (take && plain && op_i == `CWM_OP_WORD_ADD |-> ##2 (pair_wr_o == 4'h1
            && accumulator_pair_o == $past(accumulator_pair_i, 2) + $past(opnd_b_i, 2)))
        else $error("word add sum wrong");
    flash_time_a:
        assert property (take && flash_op && !seg_prefix_i |-> ##4 !done_o ##1 done_o)
        else $error("flash operand form not four clocks");
    flash_seg_time_a:
        assert property (take && flash_op && seg_prefix_i |-> ##5 !done_o ##1 done_o)
        else $error("segment flash form not five clocks");
    ram_fetch_time_a:
        assert property (take && op_i == `CWM_OP_WORD_ADD && ram_fetch_i && !flash_src_i &&
            !seg_prefix_i |-> ##5 !done_o ##1 done_o)
        else $error("fetch from internal memory not five clocks");
    byte_mul_a:
        assert property (take && plain && op_i == `CWM_OP_BYTE_MUL |-> ##2 (done_o &&
            flag_wr_o == 3'h0 && accumulator_pair_o ==
            $past(accumulator_pair_i[15:8], 2) * $past(accumulator_pair_i[7:0], 2)))
        else $error("byte multiply wrong");
    word_mul_a:
        assert property (take && plain && (op_i == `CWM_OP_UWORD_MUL ||
            op_i == `CWM_OP_SWORD_MUL) |-> ##3 (done_o && pair_wr_o == 4'h3 && flag_wr_o == 3'h0))
        else $error("word multiply not two clocks");
    word_div_a:
        assert property (take && plain && op_i == `CWM_OP_WORD_DIV |->
            ##1 busy_o [*8] ##2 (done_o && pair_wr_o == 4'h5 && flag_wr_o == 3'h0))
        else $error("word divide not nine clocks");
    dword_div_a:
        assert property (take && plain && op_i == `CWM_OP_DWORD_DIV |->
            ##17 !done_o ##1 (done_o && pair_wr_o == 4'hF && flag_wr_o == 3'h0))
        else $error("double word divide not seventeen clocks");
    mac_time_a:
        assert property (take && plain && (op_i == `CWM_OP_UMAC || op_i == `CWM_OP_SMAC) |->
            ##1 busy_o [*3] ##1 (done_o && flag_wr_o == 3'h3 && pair_wr_o == 4'h0))
        else $error("product sum not three clocks or wrong flags");
    psum_write_a:
        assert property (psum_wr_lo_i && !busy_o |=> psum_lo_o == $past(psum_wdata_i))
        else $error("product sum low half not written");
endmodule // cwm_unit_asserts

bind cwm_unit cwm_unit_asserts cwm_unit_asserts_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .start_i(start_i), .op_i(op_i), .flash_src_i(flash_src_i), .seg_prefix_i(seg_prefix_i),
    .ram_fetch_i(ram_fetch_i), .accumulator_pair_i(accumulator_pair_i), .opnd_b_i(opnd_b_i),
    .psum_wr_lo_i(psum_wr_lo_i), .psum_wdata_i(psum_wdata_i), .busy_o(busy_o),
    .done_o(done_o), .accumulator_pair_o(accumulator_pair_o), .pair_wr_o(pair_wr_o),
    .half_carry_flag_o(half_carry_flag_o), .carry_out_flag_o(carry_out_flag_o),
    .flag_wr_o(flag_wr_o), .psum_lo_o(psum_lo_o));
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench for the compare, arithmetic and multiply/divide unit.
// Assumes cwm_unit and its bound checker are compiled before this file.
`timescale 1ns/100ps
`default_nettype none
`include "cwm_map.vh"
`define CHECK(g, e) begin comparisons = comparisons + 1; if ((g) !== (e)) begin \
    bad_count = bad_count + 1; $display("wrong value at %0t: %h expected %h", $time, g, e); end end

module testbench;
    // ****
    // Stimulus and observed signals
    // ****
    reg clk_i = 1'b0;
    reg rst_n_i = 1'b0;
    reg start = 1'b0;
    reg [3:0] op = 4'h0;
    reg flash = 1'b0, seg = 1'b0, ram = 1'b0, pw_hi = 1'b0, pw_lo = 1'b0;
    reg [15:0] ax = 16'h0000, bc = 16'h0000, de = 16'h0000, hl = 16'h0000;
    reg [15:0] oa = 16'h0000, ob = 16'h0000, pw_data = 16'h0000;
    wire busy, done, zf, hf, cf;
    wire [15:0] ax_o, bc_o, de_o, hl_o, ps_hi, ps_lo;
    wire [3:0] pwr;
    wire [2:0] fwr;
    integer bad_count = 0, comparisons = 0, cycles = 0;

    cwm_unit cwm_unit_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .start_i(start), .op_i(op),
        .flash_src_i(flash), .seg_prefix_i(seg), .ram_fetch_i(ram),
        .accumulator_pair_i(ax), .multiplier_pair_i(bc), .divisor_pair_i(de),
        .index_pair_i(hl), .opnd_a_i(oa), .opnd_b_i(ob), .psum_wr_hi_i(pw_hi),
        .psum_wr_lo_i(pw_lo), .psum_wdata_i(pw_data), .busy_o(busy), .done_o(done),
        .accumulator_pair_o(ax_o), .multiplier_pair_o(bc_o), .divisor_pair_o(de_o),
        .index_pair_o(hl_o), .pair_wr_o(pwr), .zero_flag_o(zf), .half_carry_flag_o(hf),
        .carry_out_flag_o(cf), .flag_wr_o(fwr), .psum_hi_o(ps_hi), .psum_lo_o(ps_lo));

    // Clock at 40 MHz and a hang guard
    initial forever #12.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            bad_count = bad_count + 1;
            summarize;
        end
    end

    // Issue one operation and count clocks to done; poke retries start while busy
    task run(input [3:0] o, input f, input s, input r, input integer n, input integer poke);
        integer k;
        begin
            op = o;
            flash = f;
            seg = s;
            ram = r;
            start = 1'b1;
            @(posedge clk_i);
            #2 start = 1'b0;
            `CHECK(busy, 1'b1)
            k = 0;
            while (done !== 1'b1 && k < 40) begin
                @(posedge clk_i);
                #2 k = k + 1;
                start = (k == poke);
            end
            `CHECK(k, n)
            `CHECK(busy, 1'b0)
        end
    endtask

    task t_compare;
        begin
            ax = 16'h1080;
            oa = 16'h0034;
            ob = 16'h0035;
            run(`CWM_OP_BYTE_CMP, 0, 0, 0, 1, 0);
            `CHECK({zf, hf, cf, fwr, pwr}, {3'b011, 3'h7, 4'h0})
            oa = 16'h0100;
            run(`CWM_OP_CMP_ZERO, 0, 0, 0, 1, 0);
            `CHECK({zf, hf, cf, pwr}, {3'b100, 4'h0})
            ob = 16'h0080;
            run(`CWM_OP_IDX_CMP, 0, 0, 0, 1, 0);
            `CHECK({zf, hf, cf}, 3'b100)
            ob = 16'h0001;
            run(`CWM_OP_WORD_CMP, 0, 0, 0, 1, 0);
            `CHECK({zf, hf, cf, ax_o}, {3'b010, 16'h1080})
            $display("compare test done");
        end
    endtask

    task t_add_sub;
        begin
            ax = 16'h0FFF;
            ob = 16'hF001;
            run(`CWM_OP_WORD_ADD, 0, 0, 0, 1, 0);
            `CHECK({ax_o, zf, hf, cf, pwr}, {16'h0000, 3'b111, 4'h1})
            ax = 16'h0001;
            ob = 16'h0002;
            run(`CWM_OP_WORD_SUB, 0, 0, 0, 1, 0);
            `CHECK({ax_o, zf, hf, cf, fwr}, {16'hFFFF, 3'b011, 3'h7})
            $display("add and subtract test done");
        end
    endtask

    // Every operand source, prefix and fetch place on a word add
    task t_timing;
        integer i, base;
        begin
            ax = 16'h1234;
            ob = 16'h0001;
            for (i = 0; i < 8; i = i + 1) begin
                base = i[0] ? (i[1] ? 5 : 4) : (i[1] ? 2 : 1);
                run(`CWM_OP_WORD_ADD, i[0], i[1], i[2], i[2] ? 2 * base + 3 : base, 0);
                `CHECK(ax_o, 16'h1235)
            end
            $display("clock count test done");
        end
    endtask

    task t_mul;
        begin
            ax = 16'hFF03;
            run(`CWM_OP_BYTE_MUL, 0, 0, 0, 1, 0);
            `CHECK({ax_o, pwr, fwr}, {16'h02FD, 4'h1, 3'h0})
            ax = 16'hFFFF;
            bc = 16'h0002;
            run(`CWM_OP_UWORD_MUL, 0, 0, 0, 2, 0);
            `CHECK({bc_o, ax_o, fwr}, {32'h0001FFFE, 3'h0})
            run(`CWM_OP_SWORD_MUL, 0, 0, 0, 2, 0);
            `CHECK({bc_o, ax_o, pwr}, {32'hFFFFFFFE, 4'h3})
            $display("multiply test done");
        end
    endtask

    // A start raised mid divide must be ignored
    task t_div;
        begin
            ax = 16'h0064;
            de = 16'h0007;
            run(`CWM_OP_WORD_DIV, 0, 0, 0, 9, 3);
            `CHECK({ax_o, de_o, pwr, fwr}, {16'h000E, 16'h0002, 4'h5, 3'h0})
            ax = 16'h0000;
            bc = 16'h0001;
            de = 16'h0003;
            hl = 16'h0000;
            run(`CWM_OP_DWORD_DIV, 0, 0, 0, 17, 0);
            `CHECK({bc_o, ax_o, hl_o, de_o, pwr}, {32'h00005555, 32'h00000001, 4'hF})
            // A no-operation code right after the divide writes nothing
            run(4'hF, 0, 0, 0, 1, 0);
            `CHECK({pwr, fwr, hl_o, de_o}, {4'h0, 3'h0, 32'h00000001})
            $display("divide test done");
        end
    endtask

    task t_mac;
        begin
            pw_data = 16'h7FFF;
            pw_hi = 1'b1;
            @(posedge clk_i);
            #2 pw_hi = 1'b0;
            pw_data = 16'hFFFF;
            pw_lo = 1'b1;
            @(posedge clk_i);
            #2 pw_lo = 1'b0;
            `CHECK({ps_hi, ps_lo}, 32'h7FFFFFFF)
            ax = 16'h0001;
            bc = 16'h0001;
            run(`CWM_OP_UMAC, 0, 0, 0, 3, 0);
            `CHECK({ps_hi, ps_lo, hf, cf, fwr}, {32'h80000000, 2'b10, 3'h3})
            ax = 16'hFFFF;
            run(`CWM_OP_SMAC, 0, 0, 0, 3, 0);
            `CHECK({ps_hi, ps_lo, hf, cf, fwr}, {32'h7FFFFFFF, 2'b01, 3'h3})
            $display("product sum test done");
        end
    endtask

    task summarize;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, bad_count);
            if (bad_count == 0 && comparisons > 0) begin
                $display("Finished cleanly");
            end else begin
                $display("Finished with errors");
            end
            $finish;
        end
    endtask

    // Main sequence
    initial begin
        repeat (3) @(posedge clk_i);
        #2 rst_n_i = 1'b1;
        t_compare;
        t_add_sub;
        t_timing;
        t_mul;
        t_div;
        t_mac;
        summarize;
    end
endmodule // testbench
`default_nettype wire
